// ### rtl/frs_flash_read.sv
// How it works
// - Reset puts the command sequencer in array-read with no partial sequence.
// - Outside command sequences, reads return stored array contents in both banks.
// - Three writes then read with A6,A1,A0=0,0,1 and main select returns identifier.
// - Same prefix, read with A6,A1,A0=0,1,0 returns 01h protected, 00h not.
// - Status may be read repeatedly during program or erase without disturbing it.
// - Program status bit 7 is inverse of written bit 7 until completion.
// - Poll and toggle valid from fourth program write or sixth erase write.
// - During erase status bit 7 reads 0; afterwards array data returns.
// - Program to a protected sector is ignored; array stays unchanged.
// - Erase of only protected sectors: bit 7 reads 0 for 100 us, nothing erased.
// - Bit 6 inverts on each status read while busy and a select active.
// - Toggling stops at cycle end; reads then return addressed byte.
// - Erase of only protected sectors: bit 6 reads 0 for 100 us.
// - Error bit reads 0 normally, 1 when program or erase fails.
// - Error also raised on 0-to-1 program attempt or program time-out.
// - Error bit sticks until reset command; master retires failing sector.
// - After sector erase, bit 3 reads 0 for the window, then 1.
// - Status byte: bit 7 poll, 6 toggle, 5 error, 3 window, rest zero.
// - Reset command F0h returns to array-read after ID, protect read or error.
// - Prefix is AAh at 555h, 55h at AAAh, 90h at 555h; low 12 bits decoded.
// - Main selects route to main bank, secondary selects to secondary bank.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "frs_regs.svh"

module frs_flash_read
	import frs_pkg::*;
#(
	parameter int WIN_CYCLES = `FRS_WIN_US * `FRS_CLK_MHZ * (100 + `FRS_WIN_MARGIN_PCT) / 100,
	parameter int PROT_CYCLES = `FRS_PROT_ERASE_US * `FRS_CLK_MHZ,
	parameter int PGM_TO_CYCLES = `FRS_PGM_TIMEOUT_US * `FRS_CLK_MHZ,
	// Identifier value is arbitrary
	parameter logic [7:0] ID_CODE = 8'h5a
)
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// MCU bus
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic write_strobe_line_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// Sector selects and protection
	input wire logic [7:0] main_bank_sector_selects_in,
	input wire logic [3:0] secondary_bank_sector_selects_in,
	input wire logic [11:0] sector_protect_in,
	// Array read port
	output logic [15:0] arr_addr_out,
	input wire logic [7:0] arr_rdata_in,
	// Embedded algorithm engine
	output logic pgm_req_out,
	output logic [15:0] pgm_addr_out,
	output logic [7:0] pgm_data_out,
	output logic erase_req_out,
	output logic [11:0] erase_sectors_out,
	output logic bank_secondary_out,
	input wire logic eng_done_in,
	input wire logic eng_fail_in,
	// Status
	output logic busy_out,
	output logic error_flag_out
);

	// ****************************************
	// Decode
	// ****************************************
	frs_state_t state;
	frs_state_t next_state;
	logic [19:0] cnt;
	logic toggle;
	logic err;
	logic op_pgm;

	wire [11:0] sel = {secondary_bank_sector_selects_in, main_bank_sector_selects_in};
	wire any_main = |main_bank_sector_selects_in;
	wire any_sec = |secondary_bank_sector_selects_in;
	wire any_sel = any_main | any_sec;
	wire [11:0] a12 = addr_in[11:0];
	wire at_unl1 = (a12 == `FRS_ADDR_UNLOCK1);
	wire at_unl2 = (a12 == `FRS_ADDR_UNLOCK2);
	// Writes with no select active never reach either bank
	wire wr = write_strobe_line_in & any_sel;
	wire is_unl1 = wr & at_unl1 & (wdata_in == `FRS_CMD_UNLOCK1);
	wire is_unl2 = wr & at_unl2 & (wdata_in == `FRS_CMD_UNLOCK2);
	wire is_reset = wr & (wdata_in == `FRS_CMD_RESET);
	wire is_sector = wr & (wdata_in == `FRS_CMD_SECTOR);
	wire is_bulk = wr & at_unl1 & (wdata_in == `FRS_CMD_BULK);
	wire [11:0] sel_open = sel & ~sector_protect_in;
	wire sel_prot_any = |(sel & sector_protect_in);
	wire [11:0] bank_mask = any_sec ? 12'hf00 : 12'h0ff;
	wire [11:0] bulk_open = bank_mask & ~sector_protect_in;
	wire zero_to_one = |(wdata_in & ~arr_rdata_in);

	wire busy_st = (state == FRS_PGM_BUSY) | (state == FRS_ERS_WIN) |
		(state == FRS_ERS_BUSY) | (state == FRS_PROT_ERS) | (state == FRS_FAIL);
	// status only with a select active
	wire status_rd = rd_in & any_sel & busy_st;
	wire id_hit = rd_in & (state == FRS_IDENT) & ~addr_in[6] &
		(addr_in[1:0] == `FRS_ID_LOW_BITS) & any_main;
	wire prot_hit = rd_in & (state == FRS_IDENT) & ~addr_in[6] &
		(addr_in[1:0] == `FRS_PROT_LOW_BITS) & any_sel;

	wire win_done = (cnt == 20'(WIN_CYCLES - 1));
	wire prot_done = (cnt == 20'(PROT_CYCLES - 1));
	wire pgm_timeout = (cnt == 20'(PGM_TO_CYCLES - 1));

	// ****************************************
	// Status byte
	// ****************************************
	// inverse of programmed bit 7; erase reads 0
	wire poll_flag_bit = op_pgm & (state != FRS_PROT_ERS) & ~pgm_data_out[7];
	// forced low while faking a protected erase
	wire toggle_flag_bit = (state != FRS_PROT_ERS) & toggle;
	wire error_flag_bit = err;
	// low only inside the additional-sector window
	wire erase_window_flag_bit = (state != FRS_ERS_WIN);
	// status layout, unspecified bits read zero
	wire [7:0] status_byte = {poll_flag_bit, toggle_flag_bit, error_flag_bit, 1'b0,
		erase_window_flag_bit, 3'h0};

	// ****************************************
	// Command sequencer
	// ****************************************
	always_comb
	begin
		next_state = state;
		case (state)
			FRS_READ:
			begin
				if (is_unl1)
					next_state = FRS_UNL1;
			end
			// coded cycles, any stray byte aborts
			FRS_UNL1:
			begin
				if (wr)
					next_state = is_unl2 ? FRS_UNL2 : FRS_READ;
			end
			FRS_UNL2:
			begin
				if (wr & at_unl1 & (wdata_in == `FRS_CMD_ID))
					next_state = FRS_IDENT;
				else if (wr & at_unl1 & (wdata_in == `FRS_CMD_PROGRAM))
					next_state = FRS_PGM_DATA;
				else if (wr & at_unl1 & (wdata_in == `FRS_CMD_ERASE))
					next_state = FRS_ERS1;
				else if (wr)
					next_state = FRS_READ;
			end
			// leaves identifier mode on any write, reset command included
			FRS_IDENT:
			begin
				if (wr)
					next_state = FRS_READ;
			end
			FRS_PGM_DATA:
			begin
				if (wr & sel_prot_any)
					next_state = FRS_READ;
				else if (wr & zero_to_one)
					next_state = FRS_FAIL;
				else if (wr)
					next_state = FRS_PGM_BUSY;
			end
			FRS_ERS1:
			begin
				if (wr)
					next_state = is_unl1 ? FRS_ERS2 : FRS_READ;
			end
			FRS_ERS2:
			begin
				if (wr)
					next_state = is_unl2 ? FRS_ERS3 : FRS_READ;
			end
			FRS_ERS3:
			begin
				if (is_sector)
					next_state = (sel_open == 12'h000) ? FRS_PROT_ERS : FRS_ERS_WIN;
				else if (is_bulk)
					next_state = (bulk_open == 12'h000) ? FRS_PROT_ERS : FRS_ERS_BUSY;
				else if (wr)
					next_state = FRS_READ;
			end
			// another sector code closes the window
			FRS_ERS_WIN:
			begin
				if (is_sector | win_done)
					next_state = FRS_ERS_BUSY;
				else if (wr)
					next_state = FRS_READ;
			end
			FRS_ERS_BUSY:
			begin
				if (eng_fail_in)
					next_state = FRS_FAIL;
				else if (eng_done_in)
					next_state = FRS_READ;
			end
			FRS_PGM_BUSY:
			begin
				if (eng_fail_in | pgm_timeout)
					next_state = FRS_FAIL;
				else if (eng_done_in)
					next_state = FRS_READ;
			end
			FRS_PROT_ERS:
			begin
				if (prot_done)
					next_state = FRS_READ;
			end
			// only the reset command leaves failure
			FRS_FAIL:
			begin
				if (is_reset)
					next_state = FRS_READ;
			end
			default:
				next_state = FRS_READ;
		endcase
	end

	// status live from the last write
	wire enter_busy = (next_state != state) & ((next_state == FRS_ERS_WIN) |
		(next_state == FRS_PROT_ERS) | (next_state == FRS_PGM_BUSY));
	wire start_pgm = (state == FRS_PGM_DATA) & (next_state == FRS_PGM_BUSY);
	wire start_erase = (next_state == FRS_ERS_BUSY) & (state != FRS_ERS_BUSY);
	wire fail_set = (next_state == FRS_FAIL) & (state != FRS_FAIL);
	// set wins over the clearing reset command
	wire next_err = fail_set | (err & ~(is_reset & (state == FRS_FAIL)));
	wire [11:0] next_mask = (state == FRS_ERS3) ? (is_bulk ? bulk_open : sel_open) :
		(erase_sectors_out | sel_open);

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			state <= FRS_READ;
		else
			state <= next_state;
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cnt <= 20'h00000;
			err <= 1'b0;
		end
		else
		begin
			cnt <= (enter_busy | is_sector) ? 20'h00000 : cnt + 20'h00001;
			err <= next_err;
		end
	end

	// status reads flip bit 6; nothing else moves
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			toggle <= 1'b0;
		else if (status_rd)
			toggle <= ~toggle;
	end

	// ****************************************
	// Engine requests
	// ****************************************
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			pgm_req_out <= 1'b0;
			pgm_addr_out <= 16'h0000;
			pgm_data_out <= 8'h00;
			erase_req_out <= 1'b0;
			erase_sectors_out <= 12'h000;
			bank_secondary_out <= 1'b0;
			op_pgm <= 1'b0;
		end
		else
		begin
			pgm_req_out <= start_pgm;
			erase_req_out <= start_erase;
			if (state == FRS_PGM_DATA && wr)
			begin
				pgm_addr_out <= addr_in;
				pgm_data_out <= wdata_in;
				op_pgm <= 1'b1;
				bank_secondary_out <= any_sec;
			end
			else if (state == FRS_ERS3 || (state == FRS_ERS_WIN && is_sector))
			begin
				erase_sectors_out <= next_mask;
				op_pgm <= 1'b0;
				bank_secondary_out <= any_sec;
			end
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	assign arr_addr_out = addr_in;
	assign busy_out = busy_st;
	assign error_flag_out = err;

	// array data outside sequences; array once idle
	wire [7:0] next_rdata = status_rd ? status_byte :
		id_hit ? ID_CODE :
		prot_hit ? (sel_prot_any ? `FRS_PROT_YES : `FRS_PROT_NO) :
		arr_rdata_in;

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			rdata_out <= 8'h00;
		else if (rd_in)
			rdata_out <= next_rdata;
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);

	a_poll_program: assert property (status_rd && state == FRS_PGM_BUSY |=>
		rdata_out[7] == ~pgm_data_out[7])
		else $error("poll bit not inverted during program");
	a_poll_erase: assert property (status_rd && state == FRS_ERS_BUSY |=>
		rdata_out[7] == 1'b0)
		else $error("poll bit not zero during erase");
	a_toggle_flip: assert property (status_rd && state != FRS_PROT_ERS ##1
		status_rd && state != FRS_PROT_ERS |=> rdata_out[6] != $past(rdata_out[6]))
		else $error("toggle bit did not invert");
	a_prot_ignore: assert property (state == FRS_PGM_DATA && wr && sel_prot_any
		|=> !pgm_req_out && state == FRS_READ)
		else $error("protected program not ignored");
	a_window_low: assert property (status_rd && state == FRS_ERS_WIN |=>
		rdata_out[3] == 1'b0)
		else $error("window bit not low in window");
	a_id_code: assert property (id_hit |=> rdata_out == ID_CODE)
		else $error("identifier not returned");
	a_prot_code: assert property (prot_hit |=>
		rdata_out == (($past(sel) & $past(sector_protect_in)) != 12'h000 ? 8'h01 : 8'h00))
		else $error("protection status wrong");
	a_array_read: assert property (rd_in && state == FRS_READ |=>
		rdata_out == $past(arr_rdata_in))
		else $error("idle read not array data");
	a_err_sticky: assert property (err && !is_reset |=> err)
		else $error("error bit cleared without reset command");
	a_prot_erase: assert property (status_rd && state == FRS_PROT_ERS |=>
		rdata_out[7:6] == 2'h0)
		else $error("protected erase flags not zero");
	a_fail_error: assert property (state == FRS_PGM_BUSY && eng_fail_in |=>
		err && state == FRS_FAIL)
		else $error("failure did not raise error");

	c_program: cover property (start_pgm ##[1:1000] state == FRS_READ);
	c_window: cover property (state == FRS_ERS_WIN ##1 is_sector);
	c_ident: cover property (id_hit ##[1:20] is_reset);
	c_fail_reset: cover property (state == FRS_FAIL ##[1:50] is_reset);

endmodule

// ### rtl/frs_regs.svh
`ifndef FRS_REGS_SVH
`define FRS_REGS_SVH

// ****************************************
// Command decode
// ****************************************
`define FRS_ADDR_UNLOCK1 12'h555
`define FRS_ADDR_UNLOCK2 12'haaa
`define FRS_CMD_UNLOCK1 8'haa
`define FRS_CMD_UNLOCK2 8'h55
`define FRS_CMD_ID 8'h90
`define FRS_CMD_PROGRAM 8'ha0
`define FRS_CMD_ERASE 8'h80
`define FRS_CMD_SECTOR 8'h30
`define FRS_CMD_BULK 8'h10
`define FRS_CMD_RESET 8'hf0

// ****************************************
// Special reads and status byte layout
// ****************************************
`define FRS_ID_LOW_BITS 2'h1
`define FRS_PROT_LOW_BITS 2'h2
`define FRS_STAT_POLL 7
`define FRS_STAT_TOGGLE 6
`define FRS_STAT_ERROR 5
`define FRS_STAT_WINDOW 3
`define FRS_PROT_YES 8'h01
`define FRS_PROT_NO 8'h00

// ****************************************
// Timing
// ****************************************
`define FRS_CLK_MHZ 100
`define FRS_PROT_ERASE_US 100
`define FRS_WIN_US 100
`define FRS_WIN_MARGIN_PCT 20
`define FRS_PGM_TIMEOUT_US 1000

`endif

// ### rtl/frs_pkg.sv
package frs_pkg;
	typedef enum logic [3:0]
	{
		FRS_READ,
		FRS_UNL1,
		FRS_UNL2,
		FRS_IDENT,
		FRS_PGM_DATA,
		FRS_ERS1,
		FRS_ERS2,
		FRS_ERS3,
		FRS_PGM_BUSY,
		FRS_ERS_WIN,
		FRS_ERS_BUSY,
		FRS_PROT_ERS,
		FRS_FAIL
	} frs_state_t;
endpackage

// ### tb/frs_far_model.sv
`timescale 1ns/1ps

// ********
// Array and embedded engine stand-in
// ********
module frs_far_model
#(
	parameter int DLY = 12
)
(
	// Clock
	input wire logic clk_in,
	// Array read port
	input wire logic [15:0] arr_addr_in,
	output logic [7:0] arr_rdata_out,
	// Engine requests and answers
	input wire logic pgm_req_in,
	input wire logic [15:0] pgm_addr_in,
	input wire logic [7:0] pgm_data_in,
	input wire logic erase_req_in,
	input wire logic fail_in,
	output logic done_out,
	output logic fail_out
);
	logic [7:0] mem [0:255];
	int cnt = 0;
	logic ers = 1'b0;
	logic [7:0] pa = 8'h00;
	logic [7:0] pd = 8'h00;

	assign arr_rdata_out = mem[arr_addr_in[7:0]];

	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = i[7:0] ^ 8'h3c;
		done_out = 1'b0;
		fail_out = 1'b0;
	end

	// Slow answer, so status reads land while the operation runs
	always @(posedge clk_in)
	begin
		done_out <= 1'b0;
		fail_out <= 1'b0;
		if (pgm_req_in || erase_req_in)
		begin
			cnt <= DLY;
			ers <= erase_req_in;
			pa <= pgm_addr_in[7:0];
			pd <= pgm_data_in;
		end
		else if (cnt == 1)
		begin
			cnt <= 0;
			fail_out <= fail_in;
			done_out <= !fail_in;
			// A failed operation leaves the cells as they were
			if (!fail_in)
				for (int i = 0; i < 256; i++)
					if (ers)
						mem[i] <= 8'hff;
					else if (i == pa)
						mem[i] <= mem[i] & pd;
		end
		else if (cnt > 1)
			cnt <= cnt - 1;
	end
endmodule

// ### tb/tb_frs_flash_read.sv
`timescale 1ns/1ps

module tb_frs_flash_read;
	// Identifier value is arbitrary
	localparam logic [7:0] ID = 8'h33;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [15:0] addr_in = 16'h0000;
	logic [7:0] wdata_in = 8'h00;
	logic ws = 1'b0;
	logic rd_in = 1'b0;
	logic [7:0] msel = 8'h00;
	logic [3:0] ssel = 4'h0;
	logic [11:0] prot = 12'h000;
	logic fail = 1'b0;
	logic [7:0] rdata_out, arr_data, pgm_data, v, w;
	logic [15:0] arr_addr, pgm_addr;
	logic pgm_req, ers_req, done, efail, busy_out, error_flag_out;
	logic [11:0] ers_mask;
	logic ers_bank;
	int n_errors = 0;
	int n_checks = 0;
	int n_pgm = 0;
	int n_ers = 0;
	// Rows: address, main selects, secondary selects, expected byte
	logic [35:0] rows [4] = '{36'h0000_01_0_3c, 36'h0555_80_0_69, 36'h0aaa_00_1_96,
		36'hf0ff_00_8_c3};

	frs_flash_read #(.WIN_CYCLES(20), .PROT_CYCLES(16), .PGM_TO_CYCLES(40), .ID_CODE(ID))
	frs_flash_read_inst (
		.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.write_strobe_line_in(ws), .rd_in(rd_in), .rdata_out(rdata_out),
		.main_bank_sector_selects_in(msel), .secondary_bank_sector_selects_in(ssel),
		.sector_protect_in(prot), .arr_addr_out(arr_addr), .arr_rdata_in(arr_data),
		.pgm_req_out(pgm_req), .pgm_addr_out(pgm_addr), .pgm_data_out(pgm_data),
		.erase_req_out(ers_req), .erase_sectors_out(ers_mask), .bank_secondary_out(ers_bank),
		.eng_done_in(done), .eng_fail_in(efail), .busy_out(busy_out),
		.error_flag_out(error_flag_out)
	);

	frs_far_model #(.DLY(12)) frs_far_model_inst (
		.clk_in(clk_in), .arr_addr_in(arr_addr), .arr_rdata_out(arr_data),
		.pgm_req_in(pgm_req), .pgm_addr_in(pgm_addr), .pgm_data_in(pgm_data),
		.erase_req_in(ers_req), .fail_in(fail), .done_out(done), .fail_out(efail)
	);

	initial
	begin
		forever #5 clk_in = ~clk_in;
	end

	always @(posedge clk_in)
	begin
		n_pgm <= n_pgm + (pgm_req === 1'b1);
		n_ers <= n_ers + (ers_req === 1'b1);
	end

	// ********
	// Bus tasks and checks
	// ********
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask

	// A gap cycle after each strobe keeps one assignment per signal per step
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		ws <= 1'b1;
		@(posedge clk_in);
		ws <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		d = rdata_out;
	endtask

	// Two reads with no gap, as the master may issue them
	task automatic rd2(input logic [15:0] a, output logic [7:0] d1, output logic [7:0] d2);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		#1;
		d1 = rdata_out;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		d2 = rdata_out;
	endtask

	task automatic unl(input logic [7:0] c, input logic [15:0] a);
		wr(16'h0555, 8'haa);
		wr(16'h0aaa, 8'h55);
		wr(a, c);
	endtask

	task automatic wait_for(input logic is_err, input logic val);
		int k = 0;
		while ((is_err ? error_flag_out : busy_out) !== val && k < 60)
		begin
			@(posedge clk_in);
			#1;
			k++;
		end
		chk("wait", {7'h0, val}, {7'h0, is_err ? error_flag_out : busy_out});
		if (k >= 60)
			end_sim();
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ********
	// Sequence
	// ********
	initial
	begin
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'b1;
		#1;
		chk("busy", 8'h00, {7'h0, busy_out});
		chk("err", 8'h00, {7'h0, error_flag_out});
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			{msel, ssel} <= rows[i][19:8];
			rd(rows[i][35:20], v);
			chk("array", rows[i][7:0], v);
		end
		$display("test array done");
		msel <= 8'h01;
		ssel <= 4'h0;
		unl(8'h90, 16'h0555);
		rd(16'h0001, v);
		chk("ident", ID, v);
		wr(16'h0000, 8'hf0);
		rd(16'h0001, v);
		chk("after f0", 8'h3d, v);
		$display("test ident done");
		prot <= 12'h001;
		unl(8'h90, 16'h0555);
		rd(16'h0002, v);
		chk("prot yes", 8'h01, v);
		msel <= 8'h02;
		rd(16'h0002, v);
		chk("prot no", 8'h00, v);
		wr(16'h0000, 8'hf0);
		$display("test protect done");
		msel <= 8'h01;
		unl(8'ha0, 16'h0555);
		wr(16'h00c3, 8'h00);
		rd(16'h00c3, v);
		chk("prot pgm", 8'hff, v);
		chk("pgm reqs", 8'h00, n_pgm[7:0]);
		$display("test protected program done");
		prot <= 12'h000;
		unl(8'ha0, 16'h0555);
		wr(16'h00c3, 8'h12);
		rd2(16'h00c3, v, w);
		chk("poll", 8'h88, v & 8'ha8);
		chk("toggle", 8'h40, (v ^ w) & 8'he8);
		wait_for(1'b0, 1'b0);
		rd2(16'h00c3, v, w);
		chk("pgm data", 8'h12, v);
		chk("stable", 8'h12, w);
		$display("test program done");
		unl(8'ha0, 16'h0555);
		wr(16'h00c3, 8'h13);
		rd(16'h00c3, v);
		chk("err bit", 8'h20, v & 8'h20);
		chk("pgm reqs", 8'h01, n_pgm[7:0]);
		wr(16'h0000, 8'hf0);
		@(posedge clk_in);
		#1;
		chk("err clr", 8'h00, {7'h0, error_flag_out});
		$display("test zero to one done");
		fail <= 1'b1;
		unl(8'ha0, 16'h0555);
		wr(16'h00c3, 8'h02);
		rd(16'h00c3, v);
		chk("err low", 8'h00, v & 8'h20);
		wait_for(1'b1, 1'b1);
		rd(16'h00c3, v);
		chk("err high", 8'h20, v & 8'h20);
		wr(16'h0000, 8'hf0);
		@(posedge clk_in);
		#1;
		chk("err clr", 8'h00, {7'h0, error_flag_out});
		$display("test engine fail done");
		fail <= 1'b0;
		unl(8'h80, 16'h0555);
		unl(8'h30, 16'h0000);
		rd(16'h0000, v);
		chk("window", 8'h00, v & 8'ha8);
		// Second sector comes from another select, so the mask must grow
		msel <= 8'h02;
		wr(16'h0100, 8'h30);
		rd(16'h0000, v);
		chk("erasing", 8'h08, v & 8'h88);
		chk("ers reqs", 8'h01, n_ers[7:0]);
		chk("ers mask", 8'h03, ers_mask[7:0]);
		wait_for(1'b0, 1'b0);
		rd(16'h0000, v);
		chk("erased", 8'hff, v);
		$display("test sector erase done");
		// Bulk erase of the secondary bank with all its sectors locked
		prot <= 12'hf00;
		msel <= 8'h00;
		ssel <= 4'h1;
		unl(8'h80, 16'h0555);
		unl(8'h10, 16'h0555);
		rd2(16'h0000, v, w);
		chk("prot ers", 8'h00, (v | w) & 8'hc0);
		chk("ers bank", 8'h01, {7'h0, ers_bank});
		chk("ers mask", 8'h00, ers_mask[7:0]);
		wait_for(1'b0, 1'b0);
		chk("ers reqs", 8'h01, n_ers[7:0]);
		rd(16'h0000, v);
		chk("prev byte", 8'hff, v);
		$display("test protected erase done");
		// Reset in mid-sequence must drop the first unlock byte
		msel <= 8'h01;
		ssel <= 4'h0;
		wr(16'h0555, 8'haa);
		rstn_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		wr(16'h0aaa, 8'h55);
		wr(16'h0555, 8'h90);
		rd(16'h0001, v);
		chk("no partial", 8'hff, v);
		$display("test midrun reset done");
		end_sim();
	end
endmodule
